// ### hdl/eeprom_params.svh
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// ----------------------------------------
// device address word and array geometry
// ----------------------------------------
`define DEV_TYPE_CODE  4'ha
`define ADDR_W         12
`define PAGE_OFS_W     5
`define ROW_W          7
`define PAGE_BYTES     32
`define PAGE_COUNT     128
`define MEM_BYTES      4096
`define HI_ADDR_BITS   4
`define BITS_PER_WORD  8

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS  100
`define PROG_TIME_NS   5000000
`define PROG_CYCLES    (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define PROG_CNT_W     16

`endif

// ### hdl/eeprom_pkg.sv
`include "eeprom_params.svh"
`default_nettype none
package eeprom_pkg;

	// ----------------------------------------
	// serial front end states
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		LS_IDLE,
		LS_DEVADDR,
		LS_ADDR_HI,
		LS_ADDR_LO,
		LS_WDATA,
		LS_RDATA,
		LS_RACK
	} link_state_t;

	// ----------------------------------------
	// state of the scl domain
	// ----------------------------------------
	typedef struct packed
	{
		logic                   rst_s1;
		logic                   rst_s2;
		link_state_t            state;
		logic [3:0]             bit_cnt;
		logic [7:0]             shift;
		logic                   rw;
		logic [`ADDR_W-1:0]     addr;
		logic                   drive_low;
		logic [`PAGE_BYTES-1:0] mask;
		logic                   dirty;
		logic                   prog_wait;
		logic                   busy_seen;
		logic                   start_seen;
		logic                   stop_seen;
		logic [2:0]             strap_s1;
		logic [2:0]             strap_s2;
		logic                   wp_s1;
		logic                   wp_s2;
		logic                   busy_s1;
		logic                   busy_s2;
	} link_t;

	// ----------------------------------------
	// state of the system clock domain
	// ----------------------------------------
	typedef struct packed
	{
		logic                   stop_s1;
		logic                   stop_s2;
		logic                   stop_s3;
		logic                   start_s1;
		logic                   start_s2;
		logic                   start_s3;
		logic                   dirty_s1;
		logic                   dirty_s2;
		logic                   busy;
		logic [`PROG_CNT_W-1:0] cnt;
		logic                   bus_free;
		logic                   standby;
	} prog_t;

endpackage : eeprom_pkg
`default_nettype wire

// ### hdl/bus_cond_detect.sv
`default_nettype none
module bus_cond_detect
(
	input  wire logic sys_rst,    // clears both toggles
	input  wire logic scl_in,     // serial clock pin
	input  wire logic sda_in,     // serial data pin level
	output var  logic start_tog,  // flips on every start
	output var  logic stop_tog    // flips on every stop
);

	// ----------------------------------------
	// sda edges while scl high
	// ----------------------------------------
	// only sda edges mark these events, so sda itself is the clock here
	always_ff @(negedge sda_in or posedge sys_rst)
	begin
		if (sys_rst)
			start_tog <= 1'b0;
		else if (scl_in)
			start_tog <= ~start_tog;
	end

	always_ff @(posedge sda_in or posedge sys_rst)
	begin
		if (sys_rst)
			stop_tog <= 1'b0;
		else if (scl_in)
			stop_tog <= ~stop_tog;
	end

endmodule : bus_cond_detect
`default_nettype wire

// ### hdl/eeprom_link.sv
// Notes on behaviour
// - sample sda on rising scl, change driven sda after falling scl
// - sda is open drain: pull low or release only
// - write protect high blocks all programming; reads unaffected
// - unconnected strap counts as low; tie straps to known levels
// - 128 pages of 32 bytes, 12-bit byte address
// - sda falling while scl high is a start; commands begin with it
// - sda rising while scl high is a stop; commands end with it
// - standby right after read stop, after programming for write stop
// - acknowledge each received word by pulling sda low on 9th clock
// - standby after power-up, read stop, and finished programming
// - first word after start is device address, top nibble 1010
// - bits 5 to 7 match straps, else no ack and standby; the link idles, but the standby output stays low until a stop
// - eighth address bit: one reads, zero writes
// - byte write: two address bytes, one data byte, all acked, stop
// - stop after write starts self-timed cycle; inputs ignored meanwhile
// - programming cycle lasts at most 5 ms
// - page write takes up to 32 data bytes, each acked
// - only low five address bits increment per data byte
// - partial page programs only the bytes received
// - more than 32 bytes wrap within page and overwrite
// - no device address ack while programming; normal ack afterwards
// - address counter holds last accessed address plus one
`include "eeprom_params.svh"
`default_nettype none
module eeprom_link
#(
	parameter int PROG_CYCLES = `PROG_CYCLES  // programming time in clock cycles
)
(
	input  wire logic       clock,              // 10 MHz system clock
	input  wire logic       sys_rst,            // reset, active high; synchronous to clock, clears the start/stop toggles asynchronously
	input  wire logic       scl_in,             // serial clock from the host
	input  wire logic       sda_in,             // serial data line level
	output var  logic       sda_out,            // open-drain data, always low
	output var  logic       sda_oe_n,           // low while pulling sda low
	input  wire logic [2:0] chip_select_straps, // device address straps
	input  wire logic       write_protect,      // high blocks programming
	output var  logic       standby,            // low-power standby state
	output var  logic       prog_busy           // self-timed programming active
);
	import eeprom_pkg::*;

	localparam int PROG_LAST = PROG_CYCLES - 1;

	if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << `PROG_CNT_W))
		$error("PROG_CYCLES out of range");

	logic [7:0]             mem [`MEM_BYTES];
	logic [7:0]             page_mem [`PAGE_BYTES];
	logic                   start_tog;
	logic                   stop_tog;
	logic                   out_low_ff;
	link_t                  lc;
	link_t                  nxt_lc;
	prog_t                  pc;
	prog_t                  nxt_pc;
	logic                   start_ev;
	logic                   stop_ev;
	logic                   pwr_en;
	logic [7:0]             rd_byte;
	logic [7:0]             in_byte;
	logic                   commit;

	bus_cond_detect u_cond
	(
		.sys_rst   (sys_rst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.start_tog (start_tog),
		.stop_tog  (stop_tog)
	);

	// ----------------------------------------
	// scl domain: bit engine
	// ----------------------------------------
	// the toggles settle while scl is high and are read at the following
	// rising edge, half a bit later; a synchroniser would lose that bit
	assign start_ev = start_tog != lc.start_seen;
	assign stop_ev  = stop_tog != lc.stop_seen;
	assign rd_byte  = mem[lc.addr];
	assign in_byte  = {lc.shift[6:0], sda_in};

	always_comb
	begin
		nxt_lc = lc;
		pwr_en = 1'b0;
		nxt_lc.rst_s1    = sys_rst;
		nxt_lc.rst_s2    = lc.rst_s1;
		nxt_lc.strap_s1  = chip_select_straps;
		nxt_lc.strap_s2  = lc.strap_s1;
		nxt_lc.wp_s1     = write_protect;
		nxt_lc.wp_s2     = lc.wp_s1;
		nxt_lc.busy_s1   = pc.busy;
		nxt_lc.busy_s2   = lc.busy_s1;
		nxt_lc.start_seen = start_tog;
		nxt_lc.stop_seen  = stop_tog;
		nxt_lc.drive_low  = 1'b0;
		if (lc.rst_s2)
		begin
			nxt_lc.state     = LS_IDLE;
			nxt_lc.bit_cnt   = 4'h0;
			nxt_lc.shift     = 8'h00;
			nxt_lc.rw        = 1'b0;
			nxt_lc.addr      = 12'h000;
			nxt_lc.mask      = 32'h0000_0000;
			nxt_lc.dirty     = 1'b0;
			nxt_lc.prog_wait = 1'b0;
			nxt_lc.busy_seen = 1'b0;
		end
		else
		begin
			// a stop after stored data hands the page to the timer
			if (stop_ev && lc.dirty)
				nxt_lc.prog_wait = 1'b1;
			if (nxt_lc.prog_wait && lc.busy_s2)
			begin
				nxt_lc.busy_seen = 1'b1;
				nxt_lc.dirty     = 1'b0;
			end
			if (lc.prog_wait && lc.busy_seen && !lc.busy_s2)
			begin
				nxt_lc.prog_wait = 1'b0;
				nxt_lc.busy_seen = 1'b0;
			end
			if (start_ev)
			begin
				nxt_lc.state   = LS_DEVADDR;
				nxt_lc.bit_cnt = 4'h0;
			end
			else if (stop_ev)
				nxt_lc.state = LS_IDLE;
			unique case (nxt_lc.state)
				LS_IDLE:
				begin
					nxt_lc.bit_cnt = 4'h0;
				end
				LS_DEVADDR, LS_ADDR_HI, LS_ADDR_LO, LS_WDATA:
				begin
					if (nxt_lc.bit_cnt != 4'h8)
					begin
						nxt_lc.shift   = in_byte;
						nxt_lc.bit_cnt = nxt_lc.bit_cnt + 4'h1;
						if (nxt_lc.bit_cnt == 4'h8)
						begin
							nxt_lc.drive_low = 1'b1;
							if (nxt_lc.state == LS_DEVADDR)
							begin
								if (in_byte[7:4] != `DEV_TYPE_CODE ||
									in_byte[3:1] != lc.strap_s2 || nxt_lc.prog_wait)
								begin
									nxt_lc.drive_low = 1'b0;
									nxt_lc.state     = LS_IDLE;
								end
								nxt_lc.rw = in_byte[0];
							end
						end
					end
					else
					begin
						nxt_lc.bit_cnt = 4'h0;
						unique case (nxt_lc.state)
							LS_DEVADDR:
							begin
								if (lc.rw)
								begin
									nxt_lc.state     = LS_RDATA;
									nxt_lc.shift     = rd_byte;
									nxt_lc.drive_low = ~rd_byte[7];
								end
								else
									nxt_lc.state = LS_ADDR_HI;
							end
							LS_ADDR_HI:
							begin
								nxt_lc.addr[11:8] = lc.shift[`HI_ADDR_BITS-1:0];
								nxt_lc.state      = LS_ADDR_LO;
							end
							LS_ADDR_LO:
							begin
								nxt_lc.addr[7:0] = lc.shift;
								nxt_lc.mask      = 32'h0000_0000;
								nxt_lc.state     = LS_WDATA;
							end
							default:
							begin
								pwr_en = 1'b1;
								nxt_lc.mask[lc.addr[4:0]] = 1'b1;
								if (!lc.wp_s2)
									nxt_lc.dirty = 1'b1;
								nxt_lc.addr[4:0] = lc.addr[4:0] + 5'h01;
							end
						endcase
					end
				end
				LS_RDATA:
				begin
					nxt_lc.shift = {lc.shift[6:0], 1'b0};
					if (nxt_lc.bit_cnt == 4'h7)
					begin
						nxt_lc.state   = LS_RACK;
						nxt_lc.addr    = lc.addr + 12'h001;
						nxt_lc.bit_cnt = 4'h0;
					end
					else
					begin
						nxt_lc.drive_low = ~lc.shift[6];
						nxt_lc.bit_cnt   = nxt_lc.bit_cnt + 4'h1;
					end
				end
				LS_RACK:
				begin
					if (!sda_in)
					begin
						nxt_lc.state     = LS_RDATA;
						nxt_lc.shift     = rd_byte;
						nxt_lc.drive_low = ~rd_byte[7];
					end
					else
						nxt_lc.state = LS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge scl_in)
	begin
		lc <= nxt_lc;
	end

	// page buffer holds received bytes until the timer commits them
	always_ff @(posedge scl_in)
	begin
		if (pwr_en)
			page_mem[lc.addr[4:0]] <= lc.shift;
	end

	// ----------------------------------------
	// scl domain: pin driver
	// ----------------------------------------
	always_ff @(negedge scl_in)
	begin
		if (lc.rst_s2)
			out_low_ff <= 1'b0;
		else
			out_low_ff <= lc.drive_low;
	end

	assign sda_out  = 1'b0;
	assign sda_oe_n = ~out_low_ff;

	// ----------------------------------------
	// system domain: self-timed programming
	// ----------------------------------------
	assign commit = pc.busy && pc.cnt == '0;

	always_comb
	begin
		nxt_pc = pc;
		nxt_pc.stop_s1  = stop_tog;
		nxt_pc.stop_s2  = pc.stop_s1;
		nxt_pc.stop_s3  = pc.stop_s2;
		nxt_pc.start_s1 = start_tog;
		nxt_pc.start_s2 = pc.start_s1;
		nxt_pc.start_s3 = pc.start_s2;
		nxt_pc.dirty_s1 = lc.dirty;
		nxt_pc.dirty_s2 = pc.dirty_s1;
		if (sys_rst)
		begin
			nxt_pc.busy     = 1'b0;
			nxt_pc.cnt      = '0;
			nxt_pc.bus_free = 1'b1;
			nxt_pc.standby  = 1'b1;
		end
		else
		begin
			if (pc.start_s3 != pc.start_s2)
				nxt_pc.bus_free = 1'b0;
			if (pc.stop_s3 != pc.stop_s2)
			begin
				nxt_pc.bus_free = 1'b1;
				if (!pc.busy && pc.dirty_s2)
				begin
					nxt_pc.busy = 1'b1;
					nxt_pc.cnt  = PROG_LAST[`PROG_CNT_W-1:0];
				end
			end
			if (pc.busy)
			begin
				nxt_pc.cnt = pc.cnt - 1'b1;
				if (commit)
				begin
					nxt_pc.busy = 1'b0;
					nxt_pc.cnt  = '0;
				end
			end
			nxt_pc.standby = nxt_pc.bus_free && !nxt_pc.busy;
		end
	end

	always_ff @(posedge clock)
	begin
		pc <= nxt_pc;
	end

	// array is written only here, and read by the link only once busy is gone
	always_ff @(posedge clock)
	begin
		if (commit)
			for (int i = 0; i < `PAGE_BYTES; i++)
				if (lc.mask[i])
					mem[{lc.addr[11:5], i[4:0]}] <= page_mem[i];
	end

	assign standby   = pc.standby;
	assign prog_busy = pc.busy;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	devaddr_match_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.state == LS_DEVADDR && lc.bit_cnt == 4'h8 |-> lc.shift[3:1] == lc.strap_s2)
		else $error("address ack without strap match");
	devaddr_type_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.state == LS_DEVADDR && lc.bit_cnt == 4'h8 |-> lc.shift[7:4] == `DEV_TYPE_CODE)
		else $error("address ack with wrong type code");
	word_ack_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.state != LS_RDATA && lc.state != LS_RACK && lc.bit_cnt == 4'h8
		&& lc.state != LS_IDLE |-> lc.drive_low)
		else $error("received word not acknowledged");
	busy_no_ack_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.prog_wait && lc.bit_cnt == 4'h8 |-> lc.state != LS_DEVADDR)
		else $error("address acked during programming");
	page_wrap_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.state == LS_WDATA && lc.bit_cnt == 4'h8 && !start_ev && !stop_ev
		|=> lc.addr[11:5] == $past(lc.addr[11:5])
		&& lc.addr[4:0] == $past(lc.addr[4:0]) + 5'h01)
		else $error("page address did not wrap in place");
	protect_clean_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.wp_s2 && !lc.dirty |=> !lc.dirty)
		else $error("protected write armed programming");
	read_incr_a : assert property (@(posedge scl_in) disable iff (lc.rst_s2)
		lc.state == LS_RDATA && lc.bit_cnt == 4'h7 && !start_ev && !stop_ev
		|=> lc.addr == $past(lc.addr) + 12'h001)
		else $error("read did not advance address");
	prog_start_a : assert property (@(posedge clock) disable iff (sys_rst)
		!pc.busy && pc.dirty_s2 && pc.stop_s3 != pc.stop_s2
		|=> pc.busy && pc.cnt == PROG_LAST[`PROG_CNT_W-1:0])
		else $error("stop after write did not start programming");
	prog_len_a : assert property (@(posedge clock) disable iff (sys_rst)
		pc.busy |-> pc.cnt <= PROG_LAST[`PROG_CNT_W-1:0])
		else $error("programming counter beyond limit");
	standby_a : assert property (@(posedge clock) disable iff (sys_rst)
		standby |-> !prog_busy && pc.bus_free)
		else $error("standby during activity");

	read_seq_c  : cover property (@(posedge scl_in) lc.state == LS_RACK && !sda_in);
	page_data_c : cover property (@(posedge scl_in) pwr_en && lc.addr[4:0] == 5'h1f);
	prog_done_c : cover property (@(posedge clock) commit);
	poll_nak_c  : cover property (@(posedge scl_in) lc.prog_wait && lc.bit_cnt == 4'h7);

endmodule : eeprom_link
`default_nettype wire

// ### verification/host_model.sv
`default_nettype none
module host_model
(
	output var  logic scl,     // serial clock from host
	output var  logic sda_low, // high while host pulls sda
	input  wire logic sda      // resolved line level
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ----------
	// bit cycles
	// ----------
	// 80 ns bit: data moves 10 ns after scl falls, well clear of the edge
	task automatic xfer(input logic o, output logic i);
		#10 sda_low = ~o;
		#30 scl = 1'b1;
		#20 i = sda;
		#20 scl = 1'b0;
	endtask : xfer

	task automatic start();
		#10 sda_low = 1'b0;
		#30 scl = 1'b1;
		#20 sda_low = 1'b1;
		#20 scl = 1'b0;
	endtask : start

	// scl stays high afterwards: the clock stands still between frames
	task automatic stop();
		#10 sda_low = 1'b1;
		#30 scl = 1'b1;
		#20 sda_low = 1'b0;
		#20;
	endtask : stop

	// ----------
	// words
	// ----------
	task automatic send(input logic [7:0] d, output logic nak);
		logic x;
		for (int k = 7; k >= 0; k--)
			xfer(d[k], x);
		xfer(1'b1, nak);
	endtask : send

	task automatic recv(input logic more, output logic [7:0] d);
		logic b;
		for (int k = 7; k >= 0; k--)
		begin
			xfer(1'b1, b);
			d[k] = b;
		end
		xfer(~more, b);
	endtask : recv

	task automatic clocks(input int n);
		logic x;
		repeat (n)
			xfer(1'b1, x);
	endtask : clocks

	task automatic soft_reset();
		start();
		clocks(18);
		start();
	endtask : soft_reset
endmodule : host_model
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROG = 20;

	logic       clock;
	logic       sys_rst;
	logic [2:0] straps;
	logic       wp;
	logic       scl;
	logic       host_low;
	logic       sda_out;
	logic       sda_oe_n;
	logic       standby;
	logic       prog_busy;
	wire logic  sda;
	int         num_errors;
	int         check_count;
	logic [7:0] mem [0:4095];

	// pull-up: the line reads high whenever nobody pulls
	assign sda = ~(host_low | (~sda_oe_n & ~sda_out));

	host_model host (.scl(scl), .sda_low(host_low), .sda(sda));

	eeprom_link #(.PROG_CYCLES(PROG)) uut
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.chip_select_straps(straps),
		.write_protect(wp),
		.standby(standby),
		.prog_busy(prog_busy)
	);

	initial
	begin
		clock = 1'b0;
		forever
			#50 clock = ~clock;
	end

	// ----------
	// helpers
	// ----------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	function automatic logic [7:0] dw(input logic rw);
		return {4'ha, straps, rw};
	endfunction : dw

	task automatic set_addr(input logic [11:0] a);
		logic nk;
		host.start();
		host.send(dw(1'b0), nk);
		check(8'(nk), 8'h00);
		host.send({4'hf, a[11:8]}, nk);
		check(8'(nk), 8'h00);
		host.send(a[7:0], nk);
		check(8'(nk), 8'h00);
	endtask : set_addr

	// polls while counting busy cycles; polling also feeds scl edges to the link
	task automatic settle(input logic prog);
		int   busy_n;
		int   tries;
		logic nk;
		busy_n = 0;
		tries = 0;
		nk = 1'b1;
		fork
			repeat (60) @(negedge clock)
				if (prog_busy === 1'b1)
					busy_n++;
			while (nk && tries < 40)
			begin
				host.start();
				host.send(dw(1'b0), nk);
				host.stop();
				if (tries == 0)
					check(8'(nk), 8'(prog));
				tries++;
			end
		join
		if (nk)
		begin
			num_errors++;
			report_and_stop();
		end
		check(8'(busy_n), prog ? 8'(PROG) : 8'h00);
		repeat (6) @(negedge clock);
		check(8'(standby), 8'h01);
	endtask : settle

	task automatic write_page(input logic [11:0] a, input int n, input logic [7:0] d0);
		logic        nk;
		logic [11:0] p;
		set_addr(a);
		for (int k = 0; k < n; k++)
		begin
			p = {a[11:5], 5'(a[4:0] + 5'(k))};
			host.send(d0 + 8'(k), nk);
			check(8'(nk), 8'h00);
			if (!wp)
				mem[p] = d0 + 8'(k);
		end
		host.stop();
		settle(!wp);
	endtask : write_page

	task automatic read_check(input logic [11:0] a, input int n);
		logic       nk;
		logic [7:0] d;
		set_addr(a);
		host.start();
		host.send(dw(1'b1), nk);
		check(8'(nk), 8'h00);
		for (int k = 0; k < n; k++)
		begin
			host.recv(k < n - 1, d);
			check(d, mem[a + 12'(k)]);
		end
		host.stop();
		repeat (4) @(negedge clock);
		check(8'(standby), 8'h01);
	endtask : read_check

	// ----------
	// scenarios
	// ----------
	task automatic t_byte();
		write_page(12'h3a7, 1, 8'hc3);
		read_check(12'h3a7, 1);
	endtask : t_byte

	// starts at the last offset of a row and runs two bytes past a full page
	task automatic t_page();
		write_page(12'ha5f, 34, 8'h40);
		read_check(12'ha40, 32);
		write_page(12'ha4a, 2, 8'h90);
		read_check(12'ha49, 4);
	endtask : t_page

	task automatic t_protect();
		@(posedge clock);
		#1 wp = 1'b1;
		write_page(12'h3a7, 1, 8'h5a);
		read_check(12'h3a7, 1);
		@(posedge clock);
		#1 wp = 1'b0;
	endtask : t_protect

	task automatic t_refuse();
		logic [7:0] bad [3];
		logic       nk;
		bad = '{{4'hb, straps, 1'b0}, {4'ha, straps ^ 3'h1, 1'b0}, {4'ha, straps ^ 3'h4, 1'b1}};
		foreach (bad[i])
		begin
			host.start();
			host.send(bad[i], nk);
			check(8'(nk), 8'h01);
			host.send(8'h00, nk);
			check(8'(nk), 8'h01);
			host.stop();
		end
	endtask : t_refuse

	task automatic t_recover();
		logic       nk;
		logic [7:0] d;
		host.start();
		host.send(dw(1'b0), nk);
		host.send(8'h0a, nk);
		host.send(8'h45, nk);
		host.clocks(3);
		host.soft_reset();
		host.send(dw(1'b1), nk);
		check(8'(nk), 8'h00);
		host.recv(1'b0, d);
		check(d, mem[12'ha45]);
		host.stop();
	endtask : t_recover

	task automatic t_straps();
		@(posedge clock);
		#1 straps = 3'h2;
		read_check(12'ha40, 2);
	endtask : t_straps

	initial
	begin
		sys_rst = 1'b1;
		straps = 3'h5;
		wp = 1'b0;
		num_errors = 0;
		check_count = 0;
		fork
			repeat (4) @(posedge clock);
			host.clocks(6);
		join
		check(8'({standby, prog_busy, sda_oe_n, sda_out}), 8'h0a);
		@(posedge clock);
		#1 sys_rst = 1'b0;
		host.clocks(3);
		t_byte();
		t_page();
		t_protect();
		t_refuse();
		t_recover();
		t_straps();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
